/* File: inc/pcmc_pkg.sv */
// package for the port charging mode controller
package pcmc_pkg;
  localparam int PCMC_PORTS = 4;
  // register offsets
  localparam logic [7:0] PCMC_REG_PWR = 8'h05;
  localparam logic [7:0] PCMC_REG_CHG = 8'h06;
  localparam logic [7:0] PCMC_REG_CFG = 8'h0A;
  localparam logic [7:0] PCMC_REG_SEQ = 8'h25;
  localparam logic [7:0] PCMC_REG_STAT = 8'h30;
  localparam logic [7:0] PCMC_REG_MODE = 8'h31;
  // field positions
  localparam int PCMC_PWR_DIS_N_BIT = 0;
  localparam int PCMC_PWR_GANGED_BIT = 1;
  localparam int PCMC_CFG_POL_BIT = 0;
  localparam int PCMC_CFG_AUTO_DIS_N_BIT = 1;
  localparam int PCMC_CFG_HICUR_BIT = 4;
  localparam int PCMC_SEQ_FULL_BIT = 0;
  localparam int PCMC_SEQ_VND_DIS_N_BIT = 1;
  // reset values
  localparam logic [7:0] PCMC_PWR_RST = 8'h00;
  localparam logic [7:0] PCMC_CFG_RST = 8'h10;
  localparam logic [7:0] PCMC_SEQ_RST = 8'h02;
  // power-off gap between mode changes
  localparam int PCMC_OFF_TIME_NS = 100000;
  localparam int PCMC_CLK_NS = 10;
  localparam int PCMC_OFF_CYCLES = PCMC_OFF_TIME_NS / PCMC_CLK_NS;
  localparam int PCMC_CNT_W = 16;

  typedef enum logic [2:0] {
    PCMC_M_NONE, PCMC_M_CDP, PCMC_M_DCP, PCMC_M_DIV_HI, PCMC_M_DIV_MID,
    PCMC_M_DIV_LO, PCMC_M_VND
  } pcmc_mode_t;

  // per port state
  typedef struct packed {
    pcmc_mode_t mode;
    pcmc_mode_t target;
    logic off;
    logic [PCMC_CNT_W-1:0] cnt;
    logic pwr;
  } pcmc_port_t;

  // register bus signals
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcmc_bus_t;
endpackage

/* File: verilog/pcmc_ctrl.sv */
// port charging mode controller with power-switch enable sequencing
`timescale 1ns/1ps
module pcmc_ctrl
  import pcmc_pkg::*;
#(
  parameter int OFF_CYCLES = PCMC_OFF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic vbus_valid,
  input wire logic upstream_configured,
  input wire logic [PCMC_PORTS-1:0] host_port_power,
  input wire logic upstream_connected,
  input wire logic [PCMC_PORTS-1:0] dp_pullup_detect,
  input wire logic [PCMC_PORTS-1:0] data_voltage_detect,
  input wire logic strap_mode,
  input wire logic [PCMC_PORTS-1:0] charge_enable_strap,
  input wire logic power_enable_polarity_strap,
  input wire logic otp_vendor_disable_n,
  output logic [PCMC_PORTS-1:0] port_power_enable,
  output logic [PCMC_PORTS-1:0] divider_drive,
  output logic [2*PCMC_PORTS-1:0] divider_level,
  output logic [PCMC_PORTS-1:0] per_port_power
);

  typedef struct packed {
    logic [7:0] pwr;
    logic [PCMC_PORTS-1:0] chg;
    logic [7:0] cfg;
    logic [7:0] seq;
    logic [PCMC_PORTS-1:0] strap_chg;
    logic strap_pol;
    logic sampled;
    logic [7:0] rdata;
    pcmc_port_t [PCMC_PORTS-1:0] port;
    logic [PCMC_PORTS-1:0] pen;
    logic [PCMC_PORTS-1:0] ddrv;
    logic [2*PCMC_PORTS-1:0] dlvl;
    logic [PCMC_PORTS-1:0] ppm;
  } pcmc_state_t;

  pcmc_state_t s_reg, s_next;
  pcmc_bus_t bus;

  // effective configuration
  logic [PCMC_PORTS-1:0] chg_en;
  logic auto_en, hicur, full_seq, vnd_en, pol, ganged, sw_en;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  // strap mode takes enables from straps and runs every divider
  assign chg_en = strap_mode ? s_reg.strap_chg : s_reg.chg;
  assign auto_en = strap_mode | ~s_reg.cfg[PCMC_CFG_AUTO_DIS_N_BIT];
  assign hicur = strap_mode | s_reg.cfg[PCMC_CFG_HICUR_BIT];
  assign full_seq = strap_mode | s_reg.seq[PCMC_SEQ_FULL_BIT];
  assign vnd_en = strap_mode ? ~otp_vendor_disable_n
                             : ~s_reg.seq[PCMC_SEQ_VND_DIS_N_BIT];
  assign pol = strap_mode ? s_reg.strap_pol
                          : s_reg.cfg[PCMC_CFG_POL_BIT];
  assign sw_en = ~s_reg.pwr[PCMC_PWR_DIS_N_BIT];
  assign ganged = s_reg.pwr[PCMC_PWR_GANGED_BIT];

  // next step of the automatic sequence after a detection
  function automatic pcmc_mode_t next_mode(input pcmc_mode_t m);
    pcmc_mode_t after_div;
    after_div = vnd_en ? PCMC_M_VND : PCMC_M_DCP;
    next_mode = PCMC_M_DCP;
    unique case (m)
      PCMC_M_DIV_HI: next_mode = full_seq ? PCMC_M_DIV_MID : after_div;
      PCMC_M_DIV_MID: next_mode = full_seq ? PCMC_M_DIV_LO : after_div;
      PCMC_M_DIV_LO: next_mode = after_div;
      PCMC_M_VND: next_mode = PCMC_M_DCP;
      default: next_mode = PCMC_M_DCP;
    endcase
  endfunction

  // top divider level depends on the high-current selection
  function automatic pcmc_mode_t top_div();
    top_div = hicur ? PCMC_M_DIV_HI : PCMC_M_DIV_MID;
  endfunction

  // state update: registers, straps and per-port sequencers
  always_comb begin
    pcmc_mode_t want;
    logic detect;
    logic pwr_on;
    logic seq_run;
    want = PCMC_M_NONE;
    seq_run = 1'b0;
    detect = 1'b0;
    pwr_on = 1'b0;
    s_next = s_reg;
    s_next.rdata = 8'h00;
    // straps caught on the first enabled edge after release
    if (!s_reg.sampled) begin
      s_next.sampled = 1'b1;
      s_next.strap_chg = charge_enable_strap;
      s_next.strap_pol = power_enable_polarity_strap;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        PCMC_REG_PWR: s_next.pwr = bus.wdata;
        PCMC_REG_CHG: s_next.chg = bus.wdata[PCMC_PORTS-1:0];
        PCMC_REG_CFG: s_next.cfg = bus.wdata;
        PCMC_REG_SEQ: s_next.seq = bus.wdata;
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        PCMC_REG_PWR: s_next.rdata = s_reg.pwr;
        PCMC_REG_CHG: s_next.rdata = {4'h0, s_reg.chg};
        PCMC_REG_CFG: s_next.rdata = s_reg.cfg;
        PCMC_REG_SEQ: s_next.rdata = s_reg.seq;
        PCMC_REG_STAT: s_next.rdata = {s_reg.ddrv, s_reg.pen};
        PCMC_REG_MODE: s_next.rdata = {5'h00, s_reg.port[0].mode};
        default: s_next.rdata = 8'h00;
      endcase
    end
    for (int i = 0; i < PCMC_PORTS; i++) begin
      detect = dp_pullup_detect[i];
      seq_run = 1'b0;
      // desired mode when no automatic transition is pending
      if (!chg_en[i]) begin
        want = PCMC_M_NONE;
      end else if (upstream_connected) begin
        // leaving the automatic sequence on connect
        want = (vbus_valid && upstream_configured && host_port_power[i])
               ? PCMC_M_CDP : PCMC_M_NONE;
      end else if (!auto_en) begin
        want = PCMC_M_DCP;
      end else begin
        // automatic sequence, gating via the branch above
        seq_run = 1'b1;
        unique case (s_reg.port[i].target)
          PCMC_M_DIV_HI, PCMC_M_DIV_MID, PCMC_M_DIV_LO, PCMC_M_VND:
            want = detect ? next_mode(s_reg.port[i].target)
                          : s_reg.port[i].target;
          PCMC_M_DCP:
            want = (detect || data_voltage_detect[i])
                   ? top_div() : PCMC_M_DCP;
          default: want = top_div();
        endcase
      end
      // target cleared outside the sequence, so that entering automatic
      // mode always starts again from the top divider level
      s_next.port[i].target = seq_run ? want : PCMC_M_NONE;
      // a mode change drops power for a minimum gap first
      if (want != s_reg.port[i].mode && !s_reg.port[i].off) begin
        s_next.port[i].off = 1'b1;
        s_next.port[i].cnt = '0;
      end else if (s_reg.port[i].off) begin
        if (s_reg.port[i].cnt >= PCMC_CNT_W'(OFF_CYCLES - 1)) begin
          s_next.port[i].off = 1'b0;
          s_next.port[i].mode = want;
        end else begin
          s_next.port[i].cnt = s_reg.port[i].cnt + 1'b1;
        end
      end
      // power on for unconnected charging, otherwise host power (ganged only for non-charging ports)
      pwr_on = !s_next.port[i].off &&
               (chg_en[i] ? (!upstream_connected || host_port_power[i])
                          : (ganged ? |host_port_power
                                    : host_port_power[i]));
      s_next.port[i].pwr = pwr_on & sw_en;
      s_next.pen[i] = (pwr_on & sw_en) ^ ~pol;
      s_next.ppm[i] = chg_en[i] | ~ganged;
      // divider voltage code: 3 high, 2 mid, 1 low, 0 off
      s_next.ddrv[i] = 1'b0;
      s_next.dlvl[2*i +: 2] = 2'b00;
      if (!s_next.port[i].off) begin
        unique case (s_next.port[i].mode)
          PCMC_M_DIV_HI: s_next.dlvl[2*i +: 2] = 2'b11;
          PCMC_M_DIV_MID: s_next.dlvl[2*i +: 2] = 2'b10;
          PCMC_M_DIV_LO: s_next.dlvl[2*i +: 2] = 2'b01;
          default: s_next.dlvl[2*i +: 2] = 2'b00;
        endcase
        s_next.ddrv[i] = s_next.dlvl[2*i +: 2] != 2'b00;
      end
    end
  end

  // state register; clock enable freezes everything except reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.pwr <= PCMC_PWR_RST;
      s_reg.cfg <= PCMC_CFG_RST;
      s_reg.seq <= PCMC_SEQ_RST;
      s_reg.pen <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign port_power_enable = s_reg.pen;
  assign divider_drive = s_reg.ddrv;
  assign divider_level = s_reg.dlvl;
  assign per_port_power = s_reg.ppm;

endmodule // pcmc_ctrl

/* File: dv/pcmc_ctrl_assertions.sv */
// assertion checker for the port charging mode controller
`timescale 1ns/1ps
module pcmc_ctrl_assertions
  import pcmc_pkg::*;
#(
  parameter int OFF_CYCLES = PCMC_OFF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic upstream_connected,
  input wire logic [PCMC_PORTS-1:0] dp_pullup_detect,
  input wire logic strap_mode,
  input wire logic [PCMC_PORTS-1:0] port_power_enable,
  input wire logic [PCMC_PORTS-1:0] divider_drive,
  input wire logic [2*PCMC_PORTS-1:0] divider_level,
  input wire logic [PCMC_PORTS-1:0] per_port_power
);
  logic [7:0] chg_sh, cfg_sh, seq_sh;
  logic [PCMC_CNT_W-1:0] off_cnt;
  logic pen_on0;
  assign pen_on0 = port_power_enable[0] == cfg_sh[PCMC_CFG_POL_BIT];
  // shadow copies of the charge, config and sequence registers, plus length of the off gap
  always_ff @(posedge clk) begin
    if (!nrst) begin
      chg_sh <= 8'h00;
      cfg_sh <= PCMC_CFG_RST;
      seq_sh <= PCMC_SEQ_RST;
      off_cnt <= '0;
    end else if (ce) begin
      if (wr && addr == PCMC_REG_CHG) chg_sh <= wdata;
      if (wr && addr == PCMC_REG_CFG) cfg_sh <= wdata;
      if (wr && addr == PCMC_REG_SEQ) seq_sh <= wdata;
      off_cnt <= pen_on0 ? '0 : off_cnt + 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside the read answer");
  a_no_charge: assert property ((!chg_sh[0] && !strap_mode)[*3]
    |-> !divider_drive[0]) else $error("divider on a port without charging");
  a_div_unconn: assert property (upstream_connected[*8]
    |-> divider_drive == '0) else $error("divider while connected");
  a_per_port: assert property ((chg_sh[0] && !strap_mode)[*3]
    |-> per_port_power[0]) else $error("charging port not per-port managed");
  a_level_code: assert property (divider_drive[0] ==
    (divider_level[1:0] != 2'h0)) else $error("divider level code mismatch");
  a_top_level: assert property ($rose(divider_drive[0]) && !strap_mode
    && !seq_sh[PCMC_SEQ_FULL_BIT] |-> divider_level[1:0] ==
    (cfg_sh[PCMC_CFG_HICUR_BIT] ? 2'h3 : 2'h2)) else $error("wrong top level");
  a_pullup_off: assert property ($rose(dp_pullup_detect[0])
    && divider_drive[0] && !upstream_connected |-> ##[1:3] !pen_on0)
    else $error("power stayed on after pull-up");
  a_off_gap: assert property ($rose(pen_on0) && !upstream_connected
    |-> off_cnt >= OFF_CYCLES) else $error("power off gap too short");
  c_divider: cover property ($rose(divider_drive[0]));
  c_pullup: cover property ($rose(dp_pullup_detect[0]) && divider_drive[0]);
  c_reconnect: cover property ($rose(upstream_connected));
endmodule // pcmc_ctrl_assertions
bind pcmc_ctrl pcmc_ctrl_assertions #(.OFF_CYCLES(OFF_CYCLES)) u_chk (
  .clk(clk),
  .nrst(nrst),
  .ce(ce),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .upstream_connected(upstream_connected),
  .dp_pullup_detect(dp_pullup_detect),
  .strap_mode(strap_mode),
  .port_power_enable(port_power_enable),
  .divider_drive(divider_drive),
  .divider_level(divider_level),
  .per_port_power(per_port_power)
);

/* File: dv/pcmc_partner.sv */
// portable devices behind an external power switch, one per port
`timescale 1ns/1ps
module pcmc_partner
  import pcmc_pkg::*;
#(
  parameter int DLY = 2
) (
  input wire logic clk,
  input wire logic pol,
  input wire logic [PCMC_PORTS-1:0] pen,
  input wire logic [PCMC_PORTS-1:0] div,
  input wire logic [PCMC_PORTS-1:0] want_pu,
  input wire logic [PCMC_PORTS-1:0] want_vd,
  output logic [PCMC_PORTS-1:0] dp_pu,
  output logic [PCMC_PORTS-1:0] vdat
);
  int on_cnt [PCMC_PORTS];
  logic [PCMC_PORTS-1:0] rdy = '0;
  // a device answers only after its port has been powered a while
  always @(posedge clk) begin
    for (int i = 0; i < PCMC_PORTS; i++) begin
      on_cnt[i] <= (pen[i] == pol) ? on_cnt[i] + 1 : 0;
      rdy[i] <= (pen[i] == pol) && on_cnt[i] >= DLY;
    end
  end
  // pull-up answers a divider, data voltage answers a dedicated charger
  assign dp_pu = want_pu & div & rdy;
  assign vdat = want_vd & ~div & rdy;
endmodule // pcmc_partner

/* File: dv/pcmc_ctrl_tb.sv */
// self-checking bench for the port charging mode controller
`timescale 1ns/1ps
module pcmc_ctrl_tb
  import pcmc_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d, rdata, lvl;
  logic vbus = 1'b0, cfgd = 1'b0, conn = 1'b1;
  logic ce = 1'b1, strap = 1'b0, pstrap = 1'b0, otp_n = 1'b1, ppol = 1'b0;
  logic [3:0] bstrap = 4'h0;
  logic [3:0] hpp = 4'h0, wpu = 4'h0, wvd = 4'h0, pu, vd, pen, div;
  logic [1:0] last_lvl = 2'h0;
  logic [7:0] rq[$];
  logic [1:0] lq[$];
  int miscompares = 0, comparisons = 0, cycles = 0, seed = 32'hcfed;
  always #5 clk = ~clk;
  pcmc_ctrl #(.OFF_CYCLES(4)) u_pcmc_ctrl (.clk(clk), .nrst(nrst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .vbus_valid(vbus), .upstream_configured(cfgd), .host_port_power(hpp),
    .upstream_connected(conn), .dp_pullup_detect(pu),
    .data_voltage_detect(vd), .strap_mode(strap),
    .charge_enable_strap(bstrap), .power_enable_polarity_strap(pstrap),
    .otp_vendor_disable_n(otp_n),
    .port_power_enable(pen), .divider_drive(div), .divider_level(lvl),
    .per_port_power());
  pcmc_partner u_pcmc_partner (.clk(clk), .pol(ppol), .pen(pen), .div(div),
    .want_pu(wpu), .want_vd(wvd), .dp_pu(pu), .vdat(vd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    rq.push_back(exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // let the mode settle, then read it back as the end of a test
  task automatic mode_is(input string n, input pcmc_mode_t m);
    repeat (50) @(posedge clk);
    rreg(PCMC_REG_MODE, {5'h00, m});
    $display("test %s done", n);
  endtask
  task automatic summarize();
    $display("%0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // monitor: read answers and every new port 0 divider level, plus the timeout
  always @(posedge clk) begin
    cycles++;
    if (rd_seen) chk(rdata, rq.pop_front());
    rd_seen <= rd;
    if (div[0] && lvl[1:0] != last_lvl) begin
      chk({6'h00, lvl[1:0]}, {6'h00, lq.pop_front()});
    end
    last_lvl <= div[0] ? lvl[1:0] : 2'h0;
    if (cycles > 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rreg(PCMC_REG_PWR, PCMC_PWR_RST);
    rreg(PCMC_REG_CFG, PCMC_CFG_RST);
    rreg(PCMC_REG_SEQ, PCMC_SEQ_RST);
    rreg(8'h40, 8'h00);
    d = $random(seed);
    wreg(PCMC_REG_CHG, d);
    rreg(PCMC_REG_CHG, d & 8'h0f);
    wreg(PCMC_REG_CHG, 8'h01);
    vbus <= 1'b1;
    cfgd <= 1'b1;
    hpp <= 4'hf;
    mode_is("cdp", PCMC_M_CDP);
    wreg(PCMC_REG_CFG, 8'h12);
    vbus <= 1'b0;
    conn <= 1'b0;
    mode_is("dcp", PCMC_M_DCP);
    lq.push_back(2'h2);
    wreg(PCMC_REG_CFG, 8'h00);
    mode_is("low_top", PCMC_M_DIV_MID);
    wpu <= 4'h1;
    mode_is("pullup", PCMC_M_DCP);
    wpu <= 4'h0;
    wreg(PCMC_REG_CFG, 8'h10);
    lq.push_back(2'h3);
    wvd <= 4'h1;
    mode_is("vdat", PCMC_M_DIV_HI);
    // port 0 on a divider, all enables on at the active-low level
    rreg(PCMC_REG_STAT, 8'h10);
    wvd <= 4'h0;
    wreg(PCMC_REG_SEQ, 8'h01);
    lq.push_back(2'h2);
    lq.push_back(2'h1);
    wpu <= 4'h1;
    mode_is("full", PCMC_M_VND);
    vbus <= 1'b1;
    conn <= 1'b1;
    mode_is("reconnect", PCMC_M_CDP);
    repeat (4) @(posedge clk);
    // strap mode: straps are caught again at a second reset release,
    // full sequence with the vendor step off ends on the dedicated mode
    strap <= 1'b1;
    bstrap <= 4'h1;
    conn <= 1'b0;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    lq.push_back(2'h3);
    lq.push_back(2'h2);
    lq.push_back(2'h1);
    mode_is("strap", PCMC_M_DCP);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // pcmc_ctrl_tb
